/* File: hw/pmbsf_pkg.sv */
// Purpose: constants and carrier types for the status flag bank
// Assumes: command codes and data bytes arrive already decoded
// Notes: offsets are command codes, one byte per register

package pmbsf_pkg;

    // ------------------------------------------------------------
    // command codes of the three status bytes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_LINK_ERROR_FLAG_LOGIC_MEMORY_FLAGS = 8'h7E;
    localparam logic [7:0] CMD_OTHER_FLAGS = 8'h7F;
    localparam logic [7:0] CMD_VENDOR_FAULT_FLAGS = 8'h80;

    // ------------------------------------------------------------
    // reset values and masks of latched, writable-to-clear bits
    // ------------------------------------------------------------
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] CML_LATCH_MASK = 8'hFA;
    localparam logic [7:0] OTHER_LATCH_MASK = 8'h01;
    localparam logic [7:0] VENDOR_LATCH_MASK = 8'h8E;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BAD_COMMAND_BIT = 7;
    localparam int BAD_DATA_BIT = 6;
    localparam int PEC_FAIL_BIT = 5;
    localparam int MEM_ERROR_BIT = 4;
    localparam int LOGIC_CORE_ERROR_BIT = 3;
    localparam int LINK_ERROR_BIT = 1;
    localparam int EARLIEST_ALERTER_BIT = 0;
    localparam int POWER_ON_FAULT_BIT = 7;
    localparam int SELF_CHECK_BIT = 6;
    localparam int VOUT_RESET_BIT = 3;
    localparam int BACKCHANNEL_FAULT_BIT = 2;
    localparam int SYNC_FAULT_BIT = 1;

    // one decoded command from the protocol engine
    typedef struct packed {
        logic valid;      // one-cycle strobe
        logic write;      // 1 = write byte, 0 = read byte
        logic [7:0] code; // command code
        logic [7:0] data; // write data byte
    } pmbsf_cmd_t;

    // fault events (pulses) and live conditions (levels)
    typedef struct packed {
        logic bad_command;
        logic bad_data;
        logic pec_fail;
        logic mem_error;
        logic logic_core_error;
        logic link_error;
        logic backchannel_link_error_flag_error;
        logic ro_write;
        logic first_alert;
        logic trim_check_bad;
        logic nvm_sum_bad;
        logic pin_detect_bad;
        logic vout_reset;
        logic backchannel_fault;
        logic sync_fault;
        logic self_check_busy;
        logic followers_pending;
    } pmbsf_evt_t;

endpackage

/* File: hw/pmbsf_status_flags.sv */
// Purpose: communication, other and vendor status flag bytes
// Assumes: protocol engine hands over decoded commands and events
// Notes: summary and alert request update on the same edge as flags
//
// What this block does
// - invalid command sets bad command flag
// - invalid data sets bad data flag
// - failed packet check sets its flag
// - internal memory error sets its flag
// - logic core error sets its flag
// - other bus error sets link error flag
// - unsupported bits read zero, ignore writes
// - clear faults or write one clears
// - follower reports back-channel problem as link error
// - summary bit is OR of latched bits
// - summary clears when byte fully cleared
// - earliest alerter flag set when first
// - earliest alerter reads zero without alert
// - power-on check failure sets power fault
// - live self-check bit, unlatched, read only
// - output reset event sets its flag
// - back-channel fault sets its flag
// - frequency sync fault sets its flag
// - every alerting bit has a mask
// - write to read-only command is invalid

`timescale 1ns/1ps

module pmbsf_status_flags (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // decoded commands
    input wire pmbsf_pkg::pmbsf_cmd_t cmd_i,
    input wire logic clear_faults_i,
    // fault sources
    input wire pmbsf_pkg::pmbsf_evt_t evt_i,
    input wire logic loop_follower_i,
    input wire logic alert_line_i,
    // alert masks
    input wire logic [7:0] mask_cml_i,
    input wire logic [7:0] mask_other_i,
    input wire logic [7:0] mask_vendor_i,
    // read answer
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    // summaries and alert
    output logic cml_summary_o,
    output logic other_summary_o,
    output logic vendor_summary_o,
    output logic alert_req_o
);
    import pmbsf_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] link_error_flag_logic_memory_flags; // latched byte at 0x7E
    logic [7:0] other_flags;             // latched byte at 0x7F
    logic [7:0] vendor_fault_flags;      // latched part of 0x80
    logic self_check_live;               // live bit of 0x80
    logic [7:0] next_cml;
    logic [7:0] next_other;
    logic [7:0] next_vendor;
    logic next_live;
    logic [7:0] next_rd_data;
    logic next_rd_valid;
    logic next_cml_sum;
    logic next_other_sum;
    logic next_vendor_sum;
    logic next_alert;
    // per-byte set and clear vectors
    logic [7:0] set_cml;
    logic [7:0] set_other;
    logic [7:0] set_vendor;
    logic [7:0] clr_cml;
    logic [7:0] clr_other;
    logic [7:0] clr_vendor;
    logic wr_cmd;
    logic rd_cmd;

    assign wr_cmd = cmd_i.valid & cmd_i.write;
    assign rd_cmd = cmd_i.valid & ~cmd_i.write;

    // ------------------------------------------------------------
    // next flag values: set wins over any clear in the same cycle
    // ------------------------------------------------------------
    always_comb
    begin
        set_cml = 8'h00;
        set_cml[BAD_COMMAND_BIT] = evt_i.bad_command
            | evt_i.ro_write;
        set_cml[BAD_DATA_BIT] = evt_i.bad_data;
        set_cml[PEC_FAIL_BIT] = evt_i.pec_fail;
        set_cml[MEM_ERROR_BIT] = evt_i.mem_error;
        set_cml[LOGIC_CORE_ERROR_BIT] = evt_i.logic_core_error;
        // followers fold back-channel trouble into the link flag
        set_cml[LINK_ERROR_BIT] = evt_i.link_error
            | (loop_follower_i & evt_i.backchannel_link_error_flag_error);
        set_other = 8'h00;
        set_other[EARLIEST_ALERTER_BIT] = evt_i.first_alert;
        set_vendor = 8'h00;
        set_vendor[POWER_ON_FAULT_BIT] = evt_i.trim_check_bad
            | evt_i.nvm_sum_bad | evt_i.pin_detect_bad;
        set_vendor[VOUT_RESET_BIT] = evt_i.vout_reset;
        set_vendor[BACKCHANNEL_FAULT_BIT] = evt_i.backchannel_fault;
        set_vendor[SYNC_FAULT_BIT] = evt_i.sync_fault;
        // clear faults wipes all, a write clears the ones written
        clr_cml = 8'h00;
        clr_other = 8'h00;
        clr_vendor = 8'h00;
        if (clear_faults_i)
        begin
            clr_cml = CML_LATCH_MASK;
            clr_other = OTHER_LATCH_MASK;
            clr_vendor = VENDOR_LATCH_MASK;
        end
        else if (wr_cmd && cmd_i.code == CMD_LINK_ERROR_FLAG_LOGIC_MEMORY_FLAGS)
        begin
            clr_cml = cmd_i.data & CML_LATCH_MASK;
        end
        else if (wr_cmd && cmd_i.code == CMD_OTHER_FLAGS)
        begin
            clr_other = cmd_i.data & OTHER_LATCH_MASK;
        end
        else if (wr_cmd && cmd_i.code == CMD_VENDOR_FAULT_FLAGS)
        begin
            clr_vendor = cmd_i.data & VENDOR_LATCH_MASK;
        end
        // the earliest alerter flag drops once the line is released
        if (!alert_line_i)
        begin
            clr_other = OTHER_LATCH_MASK;
        end
        // hold, clear, then set; unsupported bits forced low
        next_cml = ((link_error_flag_logic_memory_flags & ~clr_cml) | set_cml)
            & CML_LATCH_MASK;
        next_other = ((other_flags & ~clr_other) | set_other)
            & OTHER_LATCH_MASK;
        next_vendor = ((vendor_fault_flags & ~clr_vendor) | set_vendor)
            & VENDOR_LATCH_MASK;
        next_live = evt_i.self_check_busy | evt_i.followers_pending;
        // summaries follow the new flag values on the same edge
        next_cml_sum = |next_cml;
        next_other_sum = |next_other;
        next_vendor_sum = |next_vendor;
        // each latched bit can be blocked by its own mask bit
        next_alert = |(next_cml & ~mask_cml_i)
            | |(next_other & ~mask_other_i)
            | |(next_vendor & ~mask_vendor_i);
    end

    // ------------------------------------------------------------
    // read answer: current byte, one-cycle valid for mapped codes
    // ------------------------------------------------------------
    always_comb
    begin
        next_rd_data = 8'h00;
        next_rd_valid = 1'b0;
        if (rd_cmd && cmd_i.code == CMD_LINK_ERROR_FLAG_LOGIC_MEMORY_FLAGS)
        begin
            next_rd_data = link_error_flag_logic_memory_flags;
            next_rd_valid = 1'b1;
        end
        else if (rd_cmd && cmd_i.code == CMD_OTHER_FLAGS)
        begin
            next_rd_data = other_flags;
            next_rd_valid = 1'b1;
        end
        else if (rd_cmd && cmd_i.code == CMD_VENDOR_FAULT_FLAGS)
        begin
            next_rd_data = vendor_fault_flags;
            next_rd_data[SELF_CHECK_BIT] = self_check_live;
            next_rd_valid = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            link_error_flag_logic_memory_flags <= FLAGS_RESET;
            other_flags <= FLAGS_RESET;
            vendor_fault_flags <= FLAGS_RESET;
            self_check_live <= 1'b0;
            rd_data_o <= 8'h00;
            rd_valid_o <= 1'b0;
            cml_summary_o <= 1'b0;
            other_summary_o <= 1'b0;
            vendor_summary_o <= 1'b0;
            alert_req_o <= 1'b0;
        end
        else
        begin
            link_error_flag_logic_memory_flags <= next_cml;
            other_flags <= next_other;
            vendor_fault_flags <= next_vendor;
            self_check_live <= next_live;
            rd_data_o <= next_rd_data;
            rd_valid_o <= next_rd_valid;
            cml_summary_o <= next_cml_sum;
            other_summary_o <= next_other_sum;
            vendor_summary_o <= next_vendor_sum;
            alert_req_o <= next_alert;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    // no clearing source touches the CML byte
    sequence s_no_cml_clear;
        !clear_faults_i && !(wr_cmd
            && cmd_i.code == CMD_LINK_ERROR_FLAG_LOGIC_MEMORY_FLAGS);
    endsequence

    property p_bad_command_sets;
        evt_i.bad_command |=> link_error_flag_logic_memory_flags[BAD_COMMAND_BIT];
    endproperty
    a_bad_command_sets: assert property (p_bad_command_sets)
        else $error("bad command flag not set");

    property p_pec_sets;
        evt_i.pec_fail |=> link_error_flag_logic_memory_flags[PEC_FAIL_BIT]
            && cml_summary_o;
    endproperty
    a_pec_sets: assert property (p_pec_sets)
        else $error("pec flag or summary not set");

    property p_reserved_zero;
        (link_error_flag_logic_memory_flags & ~CML_LATCH_MASK) == 8'h00
            && (other_flags & ~OTHER_LATCH_MASK) == 8'h00
            && (vendor_fault_flags & ~VENDOR_LATCH_MASK) == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("unsupported bit reads nonzero");

    property p_write_one_clears;
        (wr_cmd && cmd_i.code == CMD_LINK_ERROR_FLAG_LOGIC_MEMORY_FLAGS
            && cmd_i.data[BAD_DATA_BIT] && !evt_i.bad_data)
            |=> !link_error_flag_logic_memory_flags[BAD_DATA_BIT];
    endproperty
    a_write_one_clears: assert property (p_write_one_clears)
        else $error("write of one did not clear");

    property p_clear_faults_all;
        (clear_faults_i && set_cml == 8'h00)
            |=> link_error_flag_logic_memory_flags == 8'h00 && !cml_summary_o;
    endproperty
    a_clear_faults_all: assert property (p_clear_faults_all)
        else $error("clear faults left cml bits");

    property p_summary_or;
        cml_summary_o == (|link_error_flag_logic_memory_flags)
            && vendor_summary_o == (|vendor_fault_flags);
    endproperty
    a_summary_or: assert property (p_summary_or)
        else $error("summary differs from OR of flags");

    property p_follower_backchannel;
        (loop_follower_i && evt_i.backchannel_link_error_flag_error)
            |=> link_error_flag_logic_memory_flags[LINK_ERROR_BIT];
    endproperty
    a_follower_backchannel: assert property (p_follower_backchannel)
        else $error("follower back-channel error not reported");

    property p_first_alert;
        evt_i.first_alert |=> other_flags[EARLIEST_ALERTER_BIT];
    endproperty
    a_first_alert: assert property (p_first_alert)
        else $error("earliest alerter flag not set");

    property p_alert_released;
        (!alert_line_i && !evt_i.first_alert)
            |=> !other_flags[EARLIEST_ALERTER_BIT];
    endproperty
    a_alert_released: assert property (p_alert_released)
        else $error("earliest alerter flag kept without alert");

    property p_live_bit_read;
        (rd_cmd && cmd_i.code == CMD_VENDOR_FAULT_FLAGS)
            |=> rd_valid_o && rd_data_o[SELF_CHECK_BIT]
            == $past(self_check_live);
    endproperty
    a_live_bit_read: assert property (p_live_bit_read)
        else $error("live self-check bit read wrong");

    property p_ro_write;
        evt_i.ro_write |=> link_error_flag_logic_memory_flags[BAD_COMMAND_BIT]
            && cml_summary_o;
    endproperty
    a_ro_write: assert property (p_ro_write)
        else $error("read-only write not flagged");

    property p_hold;
        link_error_flag_logic_memory_flags[MEM_ERROR_BIT] ##0 s_no_cml_clear
            |=> link_error_flag_logic_memory_flags[MEM_ERROR_BIT];
    endproperty
    a_hold: assert property (p_hold)
        else $error("latched flag dropped without clear");

    property p_all_masked;
        (mask_cml_i == 8'hFF && mask_other_i == 8'hFF
            && mask_vendor_i == 8'hFF) |=> !alert_req_o;
    endproperty
    a_all_masked: assert property (p_all_masked)
        else $error("alert raised with all bits masked");

endmodule

/* File: dv/pmbsf_host_model.sv */
// Purpose: host side model issuing decoded status commands
// Assumes: one command at a time, launched at the falling edge
// Notes: released code and data lines show inverted values
`timescale 1ns/1ps
module pmbsf_host_model (
    // clock
    input wire logic clk_i,
    // command side
    output pmbsf_pkg::pmbsf_cmd_t cmd_o,
    output logic clear_faults_o,
    // read answer
    input wire logic [7:0] rd_data_i,
    input wire logic rd_valid_i
);
    import pmbsf_pkg::*;
    // ------------------------------------------------------------
    // command tasks
    // ------------------------------------------------------------
    // idle lines at time zero
    initial
    begin
        cmd_o = '0;
        clear_faults_o = 1'b0;
    end
    // one-cycle strobe; stale code and data never linger
    task automatic issue(input logic w, input logic [7:0] c,
                         input logic [7:0] d);
        @(negedge clk_i);
        cmd_o = {1'b1, w, c, d};
        @(negedge clk_i);
        cmd_o = {1'b0, ~w, ~c, ~d};
    endtask
    // read byte: answer stands from the taking edge to the next one,
    // so it is picked up at the falling edge in between
    task automatic rd(input logic [7:0] c, output logic [7:0] d,
                      output logic got);
        issue(1'b0, c, 8'h00);
        got = rd_valid_i;
        d = rd_data_i;
    endtask
    // write byte: ones clear latched flags, zeros leave them
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        issue(1'b1, c, d);
    endtask
    // clear-all strobe
    task automatic clr();
        @(negedge clk_i);
        clear_faults_o = 1'b1;
        @(negedge clk_i);
        clear_faults_o = 1'b0;
    endtask
endmodule

/* File: dv/test_pmbsf_status_flags.sv */
// Purpose: self-checking bench of the status flag bank
// Assumes: host model drives commands, bench drives fault events
// Notes: expectations come from bit positions of each status byte
`timescale 1ns/1ps
module test_pmbsf_status_flags;
    import pmbsf_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    pmbsf_evt_t evt_i = '0;
    logic loop_follower_i = 1'b0;
    logic alert_line_i = 1'b0;
    logic [7:0] mask_cml_i = 8'h00;
    logic [7:0] mask_other_i = 8'h00;
    logic [7:0] mask_vendor_i = 8'h00;
    pmbsf_cmd_t cmd_i;
    logic clear_faults_i;
    logic [7:0] rd_data_o;
    logic rd_valid_o, cml_summary_o, other_summary_o;
    logic vendor_summary_o, alert_req_o;
    int bad_count = 0;
    int check_count = 0;
    always #4 clk_i = ~clk_i;
    pmbsf_status_flags pmbsf_status_flags_inst (.clk_i(clk_i),
        .reset_i(reset_i), .cmd_i(cmd_i),
        .clear_faults_i(clear_faults_i), .evt_i(evt_i),
        .loop_follower_i(loop_follower_i), .alert_line_i(alert_line_i),
        .mask_cml_i(mask_cml_i), .mask_other_i(mask_other_i),
        .mask_vendor_i(mask_vendor_i), .rd_data_o(rd_data_o),
        .rd_valid_o(rd_valid_o), .cml_summary_o(cml_summary_o),
        .other_summary_o(other_summary_o),
        .vendor_summary_o(vendor_summary_o), .alert_req_o(alert_req_o));
    pmbsf_host_model pmbsf_host_model_inst (.clk_i(clk_i),
        .cmd_o(cmd_i), .clear_faults_o(clear_faults_i),
        .rd_data_i(rd_data_o), .rd_valid_i(rd_valid_o));
    // ------------------------------------------------------------
    // compare and helper tasks
    // ------------------------------------------------------------
    task automatic check8(input string n, input logic [7:0] x,
                          input logic [7:0] g);
        check_count++;
        if (g !== x)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic check1(input string n, input logic x, input logic g);
        check_count++;
        if (g !== x)
        begin
            bad_count++;
            $display("Error %s expected %b seen %b", n, x, g);
        end
    endtask
    // read a byte and judge answer strobe and value
    task automatic rd_chk(input logic [7:0] c, input logic [7:0] x);
        logic [7:0] d;
        logic got;
        pmbsf_host_model_inst.rd(c, d, got);
        check1("rd_valid", 1'b1, got);
        check8("rd_data", x, d);
    endtask
    // one-cycle event pulse
    task automatic pulse(input pmbsf_evt_t e);
        @(negedge clk_i);
        evt_i = e;
        @(negedge clk_i);
        evt_i = '0;
    endtask
    // summary output belonging to a status byte
    function automatic logic sum_of(input logic [7:0] c);
        if (c == CMD_LINK_ERROR_FLAG_LOGIC_MEMORY_FLAGS)
            return cml_summary_o;
        return (c == CMD_OTHER_FLAGS) ? other_summary_o : vendor_summary_o;
    endfunction
    // set, hold past the event, survive a zero write, clear by a one
    task automatic ev(input pmbsf_evt_t e, input logic [7:0] c,
                      input logic [7:0] x);
        pulse(e);
        rd_chk(c, x);
        check1("summary", 1'b1, sum_of(c));
        check1("alert_req", 1'b1, alert_req_o);
        pmbsf_host_model_inst.wr(c, 8'h00);
        rd_chk(c, x);
        pmbsf_host_model_inst.wr(c, x);
        rd_chk(c, 8'h00);
        check1("summary", 1'b0, sum_of(c));
        check1("alert_req", 1'b0, alert_req_o);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_cml();
        ev('{bad_command: 1'b1, default: 1'b0}, 8'h7E, 8'h80);
        ev('{ro_write: 1'b1, default: 1'b0}, 8'h7E, 8'h80);
        ev('{bad_data: 1'b1, default: 1'b0}, 8'h7E, 8'h40);
        ev('{pec_fail: 1'b1, default: 1'b0}, 8'h7E, 8'h20);
        ev('{mem_error: 1'b1, default: 1'b0}, 8'h7E, 8'h10);
        ev('{logic_core_error: 1'b1, default: 1'b0}, 8'h7E, 8'h08);
        ev('{link_error: 1'b1, default: 1'b0}, 8'h7E, 8'h02);
        pulse('{backchannel_link_error_flag_error: 1'b1, default: 1'b0});
        rd_chk(8'h7E, 8'h00);
        loop_follower_i = 1'b1;
        ev('{backchannel_link_error_flag_error: 1'b1, default: 1'b0}, 8'h7E, 8'h02);
    endtask
    task automatic t_other();
        alert_line_i = 1'b1;
        ev('{first_alert: 1'b1, default: 1'b0}, 8'h7F, 8'h01);
        pulse('{first_alert: 1'b1, default: 1'b0});
        alert_line_i = 1'b0;
        rd_chk(8'h7F, 8'h00);
    endtask
    task automatic t_vendor();
        ev('{trim_check_bad: 1'b1, default: 1'b0}, 8'h80, 8'h80);
        ev('{nvm_sum_bad: 1'b1, default: 1'b0}, 8'h80, 8'h80);
        ev('{pin_detect_bad: 1'b1, default: 1'b0}, 8'h80, 8'h80);
        ev('{vout_reset: 1'b1, default: 1'b0}, 8'h80, 8'h08);
        ev('{backchannel_fault: 1'b1, default: 1'b0}, 8'h80, 8'h04);
        ev('{sync_fault: 1'b1, default: 1'b0}, 8'h80, 8'h02);
    endtask
    // live bit follows busy and pending, ignores writes, never alerts
    task automatic t_live();
        evt_i.self_check_busy = 1'b1;
        pmbsf_host_model_inst.wr(8'h80, 8'h40);
        rd_chk(8'h80, 8'h40);
        check1("alert_req", 1'b0, alert_req_o);
        evt_i = '{followers_pending: 1'b1, default: 1'b0};
        rd_chk(8'h80, 8'h40);
        evt_i = '0;
        @(negedge clk_i);
        rd_chk(8'h80, 8'h00);
    endtask
    // reserved bits, foreign code, masks and clear-all
    task automatic t_misc();
        logic [7:0] d;
        logic got;
        pmbsf_host_model_inst.wr(8'h7F, 8'hFE);
        pmbsf_host_model_inst.wr(8'h80, 8'h31);
        rd_chk(8'h7F, 8'h00);
        rd_chk(8'h80, 8'h00);
        rd_chk(8'h7E, 8'h00);
        pmbsf_host_model_inst.rd(8'h81, d, got);
        check1("rd_valid_foreign", 1'b0, got);
        check8("rd_data_foreign", 8'h00, d);
        mask_cml_i = 8'h20;
        pulse('{pec_fail: 1'b1, mem_error: 1'b0, default: 1'b0});
        check1("alert_req_masked", 1'b0, alert_req_o);
        pulse('{mem_error: 1'b1, default: 1'b0});
        check1("alert_req", 1'b1, alert_req_o);
        pmbsf_host_model_inst.wr(8'h7E, 8'h20);
        rd_chk(8'h7E, 8'h10);
        check1("summary_partial", 1'b1, cml_summary_o);
        alert_line_i = 1'b1;
        pulse('{sync_fault: 1'b1, first_alert: 1'b1, default: 1'b0});
        pmbsf_host_model_inst.clr();
        rd_chk(8'h7E, 8'h00);
        rd_chk(8'h7F, 8'h00);
        rd_chk(8'h80, 8'h00);
        check1("summary_all", 1'b0, cml_summary_o | vendor_summary_o);
        // every mask bit set: flag and summary latch, alert stays quiet
        mask_cml_i = 8'hFF;
        mask_other_i = 8'hFF;
        mask_vendor_i = 8'hFF;
        pulse('{vout_reset: 1'b1, default: 1'b0});
        check1("alert_req_all_masked", 1'b0, alert_req_o);
        check1("summary_masked", 1'b1, vendor_summary_o);
        // reset in mid-run wipes the latched byte
        reset_i = 1'b1;
        @(negedge clk_i);
        reset_i = 1'b0;
        check1("summary_after_reset", 1'b0, vendor_summary_o);
        rd_chk(8'h80, 8'h00);
    endtask
    // ------------------------------------------------------------
    // verdict, main sequence and watchdog
    // ------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        reset_i = 1'b0;
        rd_chk(8'h7E, 8'h00);
        rd_chk(8'h7F, 8'h00);
        rd_chk(8'h80, 8'h00);
        t_cml();
        t_other();
        t_vendor();
        t_live();
        t_misc();
        final_report();
    end
    initial
    begin
        #100000;
        bad_count++;
        final_report();
    end
endmodule
